// ===== hw/spc_pkg.sv
// Constants and types for the per-port switch configuration register bank.
// Assumes a 10 MHz core clock; offsets are byte addresses in configuration space.
package spc_pkg;
    // Register offsets
    localparam logic [7:0]  OFS_CAP      = 8'h00;
    localparam logic [7:0]  OFS_INFO     = 8'h08;
    localparam logic [7:0]  OFS_PERF     = 8'h0c;
    localparam logic [7:0]  OFS_RANGE    = 8'h10;
    localparam logic [7:0]  OFS_SBASE    = 8'h14;
    // Capability header
    localparam logic [7:0]  CAP_ID       = 8'h08;
    localparam logic [7:0]  CAP_NEXT     = 8'h00;
    localparam logic [4:0]  CAP_TYPE     = 5'h08;
    // Port information field positions
    localparam int unsigned DP_LSB       = 0;
    localparam int unsigned DP_W         = 5;
    localparam int unsigned EN_BIT       = 5;
    localparam int unsigned CR_BIT       = 6;
    localparam int unsigned PIDX_LSB     = 8;
    localparam int unsigned PIDX_W       = 4;
    localparam int unsigned RIDX_LSB     = 16;
    localparam int unsigned RIDX_W       = 6;
    localparam int unsigned PLUG_BIT     = 22;
    localparam int unsigned HIDE_BIT     = 23;
    localparam int unsigned RENA_BIT     = 0;
    // Reset and fixed values
    localparam logic        CR_RESET     = 1'b0;
    localparam logic        CR_FIXED     = 1'b1;
    localparam logic [31:0] UNIMP_BASE   = 32'hffffffff;
    localparam logic [31:0] UNIMP_LIMIT  = 32'h00000000;
    // Counters and ranges
    localparam int unsigned NUM_CNT      = 12;
    localparam int unsigned CNT_W        = 32;
    localparam int unsigned DW_W         = 5;
    localparam int unsigned NUM_RANGES   = 4;
    localparam int unsigned RP_W         = 2;
    localparam int unsigned GRAN_LSB     = 24;
    // Reset sequencing times
    localparam int unsigned CLK_MHZ      = 10;
    localparam int unsigned PG_LOW_NS    = 1000;
    localparam int unsigned RST_HOLD_NS  = 1000;
    localparam int unsigned PG_LOW_CYC   = (PG_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_HOLD, SEQ_PG_WAIT, SEQ_RST_WAIT} spc_seq_type;
endpackage : spc_pkg

// ===== hw/spc_sat_counter.sv
// Saturating traffic counter with clear-on-read and a test write path.
// Assumes clear, write and increment all come from the core clock domain.
module spc_sat_counter
    import spc_pkg::*;
#(
    parameter int unsigned W  = 32,
    parameter int unsigned AW = 5
) (
    input  logic          clk,
    input  logic          reset,
    input  logic          warm_clear,
    input  logic [AW-1:0] add,
    input  logic          rd_clear,
    input  logic          wr_en,
    input  logic [W-1:0]  wr_data,
    output logic [W-1:0]  count
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic [W:0]   sum;

    always_comb begin
        sum = (W+1)'(count_r) + (W+1)'(add);
        if (warm_clear) begin
            count_nxt = '0;
        end else if (wr_en) begin
            count_nxt = wr_data;
        end else if (rd_clear) begin
            count_nxt = W'(add);
        end else if (sum[W]) begin
            count_nxt = '1;
        end else begin
            count_nxt = sum[W-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;

    cnt_saturate_a: assert property (@(posedge clk) disable iff (reset)
        (count_r == '1) && !warm_clear && !wr_en && !rd_clear |=> count_r == '1)
        else $error("counter wrapped past full count");
    read_keeps_inc_a: assert property (@(posedge clk) disable iff (reset)
        rd_clear && !warm_clear && !wr_en |=> count_r == W'($past(add)))
        else $error("increment lost on clearing read");
endmodule : spc_sat_counter

// ===== hw/spc_port_regs.sv
// Per-port switch configuration registers: port info, traffic counters,
// base/limit ranges, secondary base translation and internal-bus reset sequencing.
// Assumes cfg strobes, traffic events and routing requests are on clk; the plug pin is async.
//
// Notes on behaviour
// - Default port names legacy target on primary, upstream port on secondary.
// - Default port survives warm reset; new value steers after reset or link stop.
// - Primary with gate clear sends non-config requests to default port, else abort.
// - Gate set decodes through ranges; cleared by warm reset; zero on secondary.
// - Never forward to default port outside the ingress partition.
// - Cold select during bus reset drops power good and sequences reset.
// - Cold select optional: reads 1 if absent; changes mid-reset undefined.
// - Counter select picks counter; reserved selects read zero; warm reset clears.
// - Selects 0-2 rx commands, 3-5 rx dwords, 6-8 tx commands, 9-b tx dwords.
// - Reading counter data returns the value and clears that counter.
// - Counters saturate at full count; writes only for test.
// - Command counters count one per command packet on their channel.
// - Dword counters add each packet's total dwords on their channel.
// - Range index picks range and secondary base; warm reset clears it.
// - Index low bits pick word; upper bits pick the range pair.
// - Ranges 64 bit, 16 MB granular, bit 0 enables, limit low ones.
// - Unimplemented pairs read base all ones, limit all zeros.
// - Secondary base enable translates hits by the base difference.
// - Index bit 1 picks secondary base low or high word.
// - Plug status reads live hot-plug pin level; reserved on primary.
// - Hide aborts config from internal bus on primary; cold reset clears.
// - Capability block at offset 0 reports identifier 08h.
module spc_port_regs
    import spc_pkg::*;
#(
    parameter logic           PRIMARY     = 1'b1,
    parameter logic           CR_IMPL     = 1'b1,
    parameter logic           DP_WRITABLE = 1'b1,
    parameter logic [DP_W-1:0] DP_DEFAULT = 5'h01
) (
    input  logic              clk,
    input  logic              reset,
    input  logic              warm_reset,
    input  logic              link_stop_event,
    input  logic              cfg_rd,
    input  logic              cfg_wr,
    input  logic [7:0]        cfg_addr,
    input  logic [31:0]       cfg_wdata,
    output logic [31:0]       cfg_rdata,
    output logic              cfg_rack,
    input  logic              req_valid,
    input  logic              req_is_cfg,
    input  logic              req_compat,
    input  logic              req_from_vib,
    input  logic [63:0]       req_addr,
    input  logic [31:0]       ingress_mask,
    output logic              rt_valid,
    output logic              rt_default,
    output logic              rt_abort,
    output logic              rt_range_hit,
    output logic [63:0]       rt_xlat_addr,
    output logic [DP_W-1:0]   default_port_out,
    input  logic              rx_valid,
    input  logic [1:0]        rx_chan,
    input  logic [DW_W-1:0]   rx_dw,
    input  logic              tx_valid,
    input  logic [1:0]        tx_chan,
    input  logic [DW_W-1:0]   tx_dw,
    input  logic              plug_status_n_pin,
    input  logic              sec_bus_reset,
    output logic              power_good_out,
    output logic              sec_reset_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Port information group
    logic [DP_W-1:0]   dp_r, dp_nxt, dp_act_r, dp_act_nxt;
    logic              en_r, en_nxt, cr_r, cr_nxt, hide_r, hide_nxt;
    logic [PIDX_W-1:0] pidx_r, pidx_nxt;
    logic [RIDX_W-1:0] ridx_r, ridx_nxt;
    logic              cr_eff;
    logic              info_wr, range_wr, sbase_wr, perf_sel;
    logic [3:0]        pair;
    logic              pair_ok;
    logic [RP_W-1:0]   pi;

    assign info_wr  = cfg_wr && cfg_addr == OFS_INFO;
    assign range_wr = cfg_wr && cfg_addr == OFS_RANGE;
    assign sbase_wr = cfg_wr && cfg_addr == OFS_SBASE;
    assign perf_sel = cfg_addr == OFS_PERF;
    assign pair     = ridx_r[5:2];
    assign pair_ok  = 32'(pair) < NUM_RANGES;
    assign pi       = pair[RP_W-1:0];
    assign cr_eff   = CR_IMPL ? cr_r : CR_FIXED;

    always_comb begin
        dp_nxt     = dp_r;
        dp_act_nxt = dp_act_r;
        en_nxt     = en_r;
        cr_nxt     = cr_r;
        hide_nxt   = hide_r;
        pidx_nxt   = pidx_r;
        ridx_nxt   = ridx_r;
        if (warm_reset || link_stop_event) begin
            dp_act_nxt = dp_r;
        end
        if (warm_reset) begin
            en_nxt   = 1'b0;
            cr_nxt   = CR_RESET;
            pidx_nxt = '0;
            ridx_nxt = '0;
        end else if (info_wr) begin
            if (DP_WRITABLE) begin
                dp_nxt = cfg_wdata[DP_LSB +: DP_W];
            end
            en_nxt   = PRIMARY & cfg_wdata[EN_BIT];
            cr_nxt   = cfg_wdata[CR_BIT];
            hide_nxt = PRIMARY & cfg_wdata[HIDE_BIT];
            pidx_nxt = cfg_wdata[PIDX_LSB +: PIDX_W];
            ridx_nxt = cfg_wdata[RIDX_LSB +: RIDX_W];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dp_r     <= DP_DEFAULT;
            dp_act_r <= DP_DEFAULT;
            en_r     <= 1'b0;
            cr_r     <= CR_RESET;
            hide_r   <= 1'b0;
            pidx_r   <= '0;
            ridx_r   <= '0;
        end else begin
            dp_r     <= dp_nxt;
            dp_act_r <= dp_act_nxt;
            en_r     <= en_nxt;
            cr_r     <= cr_nxt;
            hide_r   <= hide_nxt;
            pidx_r   <= pidx_nxt;
            ridx_r   <= ridx_nxt;
        end
    end

    assign default_port_out = dp_act_r;

    // Range and secondary base group; bits below 16 MB are not stored
    logic [63:GRAN_LSB] base_r [NUM_RANGES];
    logic [63:GRAN_LSB] base_nxt [NUM_RANGES];
    logic [63:GRAN_LSB] lim_r [NUM_RANGES];
    logic [63:GRAN_LSB] lim_nxt [NUM_RANGES];
    logic [63:GRAN_LSB] sb_r [NUM_RANGES];
    logic [63:GRAN_LSB] sb_nxt [NUM_RANGES];
    logic [NUM_RANGES-1:0] ben_r, ben_nxt, sben_r, sben_nxt;

    always_comb begin
        base_nxt = base_r;
        lim_nxt  = lim_r;
        sb_nxt   = sb_r;
        ben_nxt  = ben_r;
        sben_nxt = sben_r;
        if (warm_reset) begin
            for (int i = 0; i < NUM_RANGES; i++) begin
                base_nxt[i] = '0;
                lim_nxt[i]  = '0;
                sb_nxt[i]   = '0;
            end
            ben_nxt  = '0;
            sben_nxt = '0;
        end else if (range_wr && pair_ok) begin
            unique case (ridx_r[1:0])
                2'h0: begin
                    base_nxt[pi][31:GRAN_LSB] = cfg_wdata[31:GRAN_LSB];
                    ben_nxt[pi]               = cfg_wdata[RENA_BIT];
                end
                2'h1: base_nxt[pi][63:32] = cfg_wdata;
                2'h2: lim_nxt[pi][31:GRAN_LSB] = cfg_wdata[31:GRAN_LSB];
                2'h3: lim_nxt[pi][63:32] = cfg_wdata;
            endcase
        end else if (sbase_wr && pair_ok) begin
            if (ridx_r[1]) begin
                sb_nxt[pi][63:32] = cfg_wdata;
            end else begin
                sb_nxt[pi][31:GRAN_LSB] = cfg_wdata[31:GRAN_LSB];
                sben_nxt[pi]            = cfg_wdata[RENA_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_RANGES; i++) begin
                base_r[i] <= '0;
                lim_r[i]  <= '0;
                sb_r[i]   <= '0;
            end
            ben_r  <= '0;
            sben_r <= '0;
        end else begin
            base_r <= base_nxt;
            lim_r  <= lim_nxt;
            sb_r   <= sb_nxt;
            ben_r  <= ben_nxt;
            sben_r <= sben_nxt;
        end
    end

    // Traffic counters
    logic [CNT_W-1:0] cnt [NUM_CNT];
    logic             perf_ok;

    assign perf_ok = 32'(pidx_r) < NUM_CNT;

    for (genvar k = 0; k < NUM_CNT; k++) begin : g_cnt
        localparam int unsigned G = k / 3;
        localparam logic [1:0]  CH = 2'(k % 3);
        logic            ev;
        logic [DW_W-1:0] amt;
        logic            sel;
        assign ev  = (G < 2) ? (rx_valid && rx_chan == CH) : (tx_valid && tx_chan == CH);
        assign amt = !ev ? '0 : (G % 2 == 0) ? DW_W'(1) : ((G < 2) ? rx_dw : tx_dw);
        assign sel = perf_sel && pidx_r == PIDX_W'(k);
        spc_sat_counter #(.W(CNT_W), .AW(DW_W)) u_cnt (
            .clk        (clk),
            .reset      (reset),
            .warm_clear (warm_reset),
            .add        (amt),
            .rd_clear   (sel && cfg_rd),
            .wr_en      (sel && cfg_wr),
            .wr_data    (cfg_wdata),
            .count      (cnt[k])
        );
    end

    // Plug pin synchroniser; level moves once stages two and three agree
    logic plug_s1_r, plug_s2_r, plug_s3_r, plug_lvl_r, plug_lvl_nxt;

    always_comb begin
        plug_lvl_nxt = (plug_s2_r == plug_s3_r) ? plug_s3_r : plug_lvl_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            plug_s1_r  <= 1'b1;
            plug_s2_r  <= 1'b1;
            plug_s3_r  <= 1'b1;
            plug_lvl_r <= 1'b1;
        end else begin
            plug_s1_r  <= plug_status_n_pin;
            plug_s2_r  <= plug_s1_r;
            plug_s3_r  <= plug_s2_r;
            plug_lvl_r <= plug_lvl_nxt;
        end
    end

    // Read path
    logic [31:0] rd_val, rdata_r, rdata_nxt;
    logic        rack_r, rack_nxt;

    always_comb begin
        rd_val = 32'h00000000;
        unique case (cfg_addr)
            OFS_CAP:   rd_val = {CAP_TYPE, 11'h000, CAP_NEXT, CAP_ID};
            OFS_INFO:  rd_val = {8'h00, hide_r, PRIMARY ? 1'b0 : plug_lvl_r, ridx_r, 4'h0,
                                 pidx_r, 1'b0, cr_eff, en_r, dp_r};
            OFS_PERF:  rd_val = perf_ok ? cnt[pidx_r] : 32'h00000000;
            OFS_RANGE: begin
                if (!pair_ok) begin
                    rd_val = ridx_r[1] ? UNIMP_LIMIT : UNIMP_BASE;
                end else begin
                    unique case (ridx_r[1:0])
                        2'h0: rd_val = {base_r[pi][31:GRAN_LSB], 23'h000000, ben_r[pi]};
                        2'h1: rd_val = base_r[pi][63:32];
                        2'h2: rd_val = {lim_r[pi][31:GRAN_LSB], 24'h000000};
                        2'h3: rd_val = lim_r[pi][63:32];
                    endcase
                end
            end
            OFS_SBASE: begin
                if (pair_ok) begin
                    rd_val = ridx_r[1] ? sb_r[pi][63:32]
                                       : {sb_r[pi][31:GRAN_LSB], 23'h000000, sben_r[pi]};
                end
            end
            default:   rd_val = 32'h00000000;
        endcase
        rdata_nxt = cfg_rd ? rd_val : rdata_r;
        rack_nxt  = cfg_rd;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_r <= '0;
            rack_r  <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rack_r  <= rack_nxt;
        end
    end

    assign cfg_rdata = rdata_r;
    assign cfg_rack  = rack_r;

    // Routing decode, one cycle latency
    logic              hit, dflt, abort;
    logic [63:0]       xlat;
    logic              rtv_r, rtd_r, rta_r, rth_r;
    logic              rtv_nxt, rtd_nxt, rta_nxt, rth_nxt;
    logic [63:0]       rtx_r, rtx_nxt;

    always_comb begin
        hit  = 1'b0;
        xlat = req_addr;
        for (int i = NUM_RANGES - 1; i >= 0; i--) begin
            if (ben_r[i] && req_addr[63:GRAN_LSB] >= base_r[i]
                         && req_addr[63:GRAN_LSB] <= lim_r[i]) begin
                hit = 1'b1;
                if (sben_r[i]) begin
                    xlat = {req_addr[63:GRAN_LSB] - base_r[i] + sb_r[i],
                            req_addr[GRAN_LSB-1:0]};
                end else begin
                    xlat = req_addr;
                end
            end
        end
        if (PRIMARY) begin
            dflt = !req_is_cfg && (!en_r || req_compat);
        end else begin
            dflt = !hit;
        end
        abort = (dflt && !ingress_mask[dp_act_r])
             || (PRIMARY && hide_r && req_is_cfg && req_from_vib);
        rtv_nxt = req_valid;
        rtd_nxt = req_valid && dflt && !abort;
        rta_nxt = req_valid && abort;
        rth_nxt = req_valid && hit && !dflt && !abort;
        rtx_nxt = req_valid ? xlat : rtx_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rtv_r <= 1'b0;
            rtd_r <= 1'b0;
            rta_r <= 1'b0;
            rth_r <= 1'b0;
            rtx_r <= '0;
        end else begin
            rtv_r <= rtv_nxt;
            rtd_r <= rtd_nxt;
            rta_r <= rta_nxt;
            rth_r <= rth_nxt;
            rtx_r <= rtx_nxt;
        end
    end

    assign rt_valid     = rtv_r;
    assign rt_default   = rtd_r;
    assign rt_abort     = rta_r;
    assign rt_range_hit = rth_r;
    assign rt_xlat_addr = rtx_r;

    // Internal bus reset sequencer; cold choice latched when reset starts
    spc_seq_type st_r, st_nxt;
    logic [7:0]  seq_cnt_r, seq_cnt_nxt;
    logic        cold_r, cold_nxt, pg_r, pg_nxt, srst_r, srst_nxt;

    always_comb begin
        st_nxt      = st_r;
        seq_cnt_nxt = seq_cnt_r;
        cold_nxt    = cold_r;
        unique case (st_r)
            SEQ_IDLE: if (sec_bus_reset) begin
                st_nxt   = SEQ_HOLD;
                cold_nxt = cr_eff;
            end
            SEQ_HOLD: if (!sec_bus_reset) begin
                st_nxt      = cold_r ? SEQ_PG_WAIT : SEQ_RST_WAIT;
                seq_cnt_nxt = cold_r ? 8'(PG_LOW_CYC) : 8'(RST_HOLD_CYC);
            end
            SEQ_PG_WAIT: if (seq_cnt_r == 8'h01) begin
                st_nxt      = SEQ_RST_WAIT;
                seq_cnt_nxt = 8'(RST_HOLD_CYC);
            end else begin
                seq_cnt_nxt = seq_cnt_r - 8'h01;
            end
            SEQ_RST_WAIT: if (seq_cnt_r == 8'h01) begin
                st_nxt = SEQ_IDLE;
            end else begin
                seq_cnt_nxt = seq_cnt_r - 8'h01;
            end
        endcase
        pg_nxt   = !(cold_nxt && (st_nxt == SEQ_HOLD || st_nxt == SEQ_PG_WAIT));
        srst_nxt = st_nxt != SEQ_IDLE;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r      <= SEQ_IDLE;
            seq_cnt_r <= '0;
            cold_r    <= 1'b0;
            pg_r      <= 1'b1;
            srst_r    <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            cold_r    <= cold_nxt;
            pg_r      <= pg_nxt;
            srst_r    <= srst_nxt;
        end
    end

    assign power_good_out = pg_r;
    assign sec_reset_out  = srst_r;

    sequence cold_start_s;
        st_r == SEQ_IDLE && sec_bus_reset && cr_eff;
    endsequence
    dp_hold_a: assert property (info_wr && !warm_reset && !link_stop_event |=>
        default_port_out == $past(default_port_out)) else $error("default port moved early");
    gate_off_a: assert property (PRIMARY && req_valid && !en_r && !req_is_cfg |=>
        rt_default || rt_abort) else $error("gate clear request not sent to default");
    partition_a: assert property (req_valid && !ingress_mask[default_port_out] |=>
        !rt_default) else $error("forward outside partition");
    warm_clear_a: assert property (warm_reset |=> !en_r && pidx_r == '0 && ridx_r == '0)
        else $error("warm reset left fields set");
    cold_pg_a: assert property (cold_start_s |=> !power_good_out ##1 !power_good_out)
        else $error("power good not dropped on cold reset");
    pg_order_a: assert property ($rose(power_good_out) |-> sec_reset_out)
        else $error("reset released before power good");
    perf_rsv_a: assert property (cfg_rd && perf_sel && !perf_ok |=> cfg_rdata == 32'h0)
        else $error("reserved counter reads nonzero");
    unimp_range_a: assert property (cfg_rd && cfg_addr == OFS_RANGE && !pair_ok |=>
        cfg_rdata == ($past(ridx_r[1]) ? UNIMP_LIMIT : UNIMP_BASE)) else $error("bad unimplemented range");
    plug_live_a: assert property ($stable(plug_status_n_pin)[*5] |-> plug_lvl_r == plug_status_n_pin)
        else $error("plug level does not follow pin");
    hide_abort_a: assert property (PRIMARY && req_valid && hide_r && req_is_cfg && req_from_vib
        |=> rt_abort) else $error("hidden port config not aborted");
endmodule : spc_port_regs

// ===== testbench/test_switch_port_config_regs.sv
// Self-checking bench for the per-port switch configuration register bank.
// Assumes the design's default parameters: primary port, four implemented range pairs.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t got %h", $time, a); end end
module test_switch_port_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset, warm_reset, link_stop_event, cfg_rd, cfg_wr, cfg_rack, req_valid, rt_valid;
    logic        rt_default, rt_abort, rt_range_hit, rx_valid, tx_valid, power_good_out, sec_reset_out;
    logic        req_is_cfg = 0, req_compat = 0, req_from_vib = 0, plug_status_n_pin = 1, sec_bus_reset = 0;
    logic [7:0]  cfg_addr;
    logic [31:0] cfg_wdata, cfg_rdata, ingress_mask, d;
    logic [63:0] req_addr, rt_xlat_addr;
    logic [1:0]  rx_chan, tx_chan;
    logic [4:0]  rx_dw, tx_dw, default_port_out;
    int          mismatches, checks;
    spc_port_regs u_spc_port_regs (.*);
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    task finish_test;
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // Each bus task waits one cycle first so a strobe never drops and rises in one step
    task wr(input [7:0] a, input [31:0] v);
        @(negedge clk) cfg_addr = a;
        cfg_wdata = v;
        cfg_wr = 1;
        @(negedge clk) cfg_wr = 0;
    endtask : wr
    task rd(input [7:0] a);
        int i;
        @(negedge clk) cfg_addr = a;
        cfg_rd = 1;
        @(negedge clk) cfg_rd = 0;
        for (i = 0; i < 3 && cfg_rack !== 1'b1; i++) @(negedge clk);
        if (cfg_rack !== 1'b1) begin
            mismatches++;
            finish_test;
        end
        d = cfg_rdata;
    endtask : rd
    task sel(input en, input [3:0] p, input [5:0] r);
        wr(8'h08, {10'h0, r, 4'h0, p, 2'b0, en, 5'h03});
    endtask : sel
    task route(input [63:0] a, input [31:0] m);
        @(negedge clk) req_addr = a;
        ingress_mask = m;
        req_valid = 1;
        @(negedge clk) req_valid = 0;
    endtask : route
    task pkt(input rx, input [1:0] ch, input [4:0] dw);
        @(negedge clk) {rx_valid, tx_valid, rx_chan, tx_chan, rx_dw, tx_dw} = {rx, !rx, ch, ch, dw, dw};
        @(negedge clk) {rx_valid, tx_valid} = 2'b00;
    endtask : pkt
    task t_info;
        rd(8'h00);
        `CHK(d[7:0], 8'h08)
        rd(8'h08);
        `CHK(d & 32'h00bf0f7f, 32'h00000001)
        sel(1, 4'h5, 6'h09);
        rd(8'h08);
        `CHK(d & 32'h00bf0f7f, 32'h00090523)
        `CHK(default_port_out, 5'h01)
        @(negedge clk) link_stop_event = 1;
        @(negedge clk) link_stop_event = 0;
        `CHK(default_port_out, 5'h03)
        @(negedge clk) warm_reset = 1;
        @(negedge clk) warm_reset = 0;
        rd(8'h08);
        `CHK(d & 32'h00bf0f7f, 32'h00000003)
    endtask : t_info
    task t_cnt;
        pkt(1, 2'd0, 5'd3);
        pkt(1, 2'd0, 5'd5);
        pkt(0, 2'd2, 5'd4);
        pkt(1, 2'd3, 5'd7);
        sel(0, 4'h0, 6'h0);
        rd(8'h0c);
        `CHK(d, 32'h2)
        rd(8'h0c);
        `CHK(d, 32'h0)
        sel(0, 4'h3, 6'h0);
        rd(8'h0c);
        `CHK(d, 32'h8)
        sel(0, 4'h8, 6'h0);
        rd(8'h0c);
        `CHK(d, 32'h1)
        sel(0, 4'hb, 6'h0);
        rd(8'h0c);
        `CHK(d, 32'h4)
        sel(0, 4'hc, 6'h0);
        rd(8'h0c);
        `CHK(d, 32'h0)
        sel(0, 4'h0, 6'h0);
        wr(8'h0c, 32'hffffffff);
        pkt(1, 2'd0, 5'd1);
        rd(8'h0c);
        `CHK(d, 32'hffffffff)
    endtask : t_cnt
    task t_range;
        sel(1, 4'h0, 6'h10);
        rd(8'h10);
        `CHK(d, 32'hffffffff)
        sel(1, 4'h0, 6'h12);
        rd(8'h10);
        `CHK(d, 32'h0)
        sel(1, 4'h0, 6'h00);
        wr(8'h10, 32'h01ffffff);
        rd(8'h10);
        `CHK(d, 32'h01000001)
        sel(1, 4'h0, 6'h02);
        wr(8'h10, 32'h02000000);
        route(64'h02ff_fff0, 32'hffffffff);
        `CHK({rt_valid, rt_default, rt_range_hit}, 3'b101)
        route(64'h0300_0000, 32'hffffffff);
        `CHK({rt_valid, rt_default, rt_range_hit}, 3'b100)
        sel(0, 4'h0, 6'h00);
        route(64'h0300_0000, 32'hffffffff);
        `CHK({rt_valid, rt_default, rt_abort}, 3'b110)
        route(64'h0300_0000, 32'h0);
        `CHK({rt_valid, rt_abort}, 2'b11)
        sel(1, 4'h0, 6'h00);
        wr(8'h14, 32'h05000001);
        rd(8'h14);
        `CHK(d, 32'h05000001)
        route(64'h0180_1234, 32'hffffffff);
        `CHK(rt_xlat_addr, 64'h0000_0000_0580_1234)
        wr(8'h08, 32'h00800023);
        {req_is_cfg, req_from_vib} = 2'b11;
        route(64'h0, 32'hffffffff);
        `CHK({rt_valid, rt_default, rt_abort}, 3'b101)
        {req_is_cfg, req_from_vib} = 2'b00;
    endtask : t_range
    // Secondary bus reset: cold select first, then warm select
    task t_seq;
        int i;
        plug_status_n_pin = 0;
        wr(8'h08, 32'h00000063);
        @(negedge clk) sec_bus_reset = 1;
        @(negedge clk) `CHK({sec_reset_out, power_good_out}, 2'b10)
        @(negedge clk) sec_bus_reset = 0;
        for (i = 0; i < 40 && power_good_out !== 1'b1; i++) @(negedge clk);
        `CHK(i, 11)
        `CHK(sec_reset_out, 1'b1)
        if (i == 40) finish_test;
        for (i = 0; i < 40 && sec_reset_out !== 1'b0; i++) @(negedge clk);
        `CHK(i, 10)
        if (i == 40) finish_test;
        wr(8'h08, 32'h00000023);
        @(negedge clk) sec_bus_reset = 1;
        @(negedge clk) `CHK({sec_reset_out, power_good_out}, 2'b11)
        @(negedge clk) sec_bus_reset = 0;
        for (i = 0; i < 40 && sec_reset_out !== 1'b0; i++) @(negedge clk);
        `CHK(i, 11)
        `CHK(power_good_out, 1'b1)
        if (i == 40) finish_test;
        rd(8'h08);
        `CHK(d[22], 1'b0)
    endtask : t_seq
    initial begin
        {reset, warm_reset, link_stop_event, cfg_rd, cfg_wr, req_valid, rx_valid, tx_valid} = 8'h80;
        {cfg_addr, cfg_wdata, req_addr, ingress_mask, rx_chan, tx_chan, rx_dw, tx_dw} = '0;
        repeat (2) @(negedge clk);
        reset = 0;
        t_info;
        t_cnt;
        t_range;
        t_seq;
        finish_test;
    end
endmodule : test_switch_port_config_regs
